// ===== ascii_router_command_parser.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Serial framing is 38.4 kbaud, one start bit, one stop bit, no parity.
// - Commands and replies are ASCII lines ended by a carriage return.
// - T, source digit, destination digit routes that source to that bus.
// - Source and destination digits must lie between one and eight.
// - T, M, bus digit selects the bus shown on the monitor output.
// - The overlay cycle command steps the overlay mode and wraps after the last.
// - Overlay order is none, source, destination, both, matrix, X-Y.
// - Every command received while the control enable bit is set is answered by one S, nine digits, carriage return message.
// - Status digits are the sources of buses one to eight, then the monitor bus.
// - Only bus one steers the physical output selection.
module ascii_router_command_parser #(
	parameter int BIT_CYCLES = router_pkg::BIT_CYC // Clock cycles per serial bit.
) (
	input wire logic mclk, // Device clock.
	input wire logic rst_b, // Asynchronous reset.
	input wire logic serial_rx, // Serial command line in.
	output logic serial_tx, // Serial status line out.
	output logic [2:0] out_sel, // Source driving the physical output.
	output logic [2:0] mon_sel, // Bus shown on the monitor.
	output router_pkg::ovl_t ovl_mode, // Monitor text overlay mode.
	input wire logic [router_pkg::AXI_AW-1:0] s_axi_awaddr, // Write address.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address ready.
	input wire logic [31:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write byte enables.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data ready.
	output logic [1:0] s_axi_bresp, // Write response.
	output logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [router_pkg::AXI_AW-1:0] s_axi_araddr, // Read address.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address ready.
	output logic [31:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read response.
	output logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready // Read data ready.
);
	localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
	localparam logic [15:0] HALF_LAST = 16'(BIT_CYCLES / 2 - 1);

	function automatic logic is_dig(input logic [7:0] c);
		is_dig = (c >= router_pkg::CH_ONE) && (c <= router_pkg::CH_EIGHT);
	endfunction

	function automatic logic [2:0] dig_val(input logic [7:0] c);
		logic [7:0] d;
		d = c - router_pkg::CH_ONE;
		dig_val = d[2:0];
	endfunction

	// ************************************************************
	// Receiver
	// ************************************************************
	router_pkg::ser_st_t rx_st_ff, nxt_rx_st;
	logic [15:0] rx_cnt_ff, nxt_rx_cnt;
	logic [2:0] rx_bit_ff, nxt_rx_bit;
	logic [7:0] rx_sh_ff, nxt_rx_sh;
	logic rx_vld_ff, nxt_rx_vld;
	logic rx_ferr_ff, nxt_rx_ferr;

	always_comb begin
		nxt_rx_st = rx_st_ff;
		nxt_rx_cnt = rx_cnt_ff + 16'h0001;
		nxt_rx_bit = rx_bit_ff;
		nxt_rx_sh = rx_sh_ff;
		nxt_rx_vld = 1'b0;
		nxt_rx_ferr = rx_ferr_ff;
		case (rx_st_ff)
			router_pkg::SER_IDLE: begin
				nxt_rx_cnt = 16'h0000;
				if (!serial_rx) begin
					nxt_rx_st = router_pkg::SER_START;
				end
			end
			router_pkg::SER_START: begin
				if (rx_cnt_ff == HALF_LAST) begin
					nxt_rx_cnt = 16'h0000;
					nxt_rx_bit = 3'h0;
					nxt_rx_st = serial_rx ? router_pkg::SER_IDLE : router_pkg::SER_DATA;
				end
			end
			router_pkg::SER_DATA: begin
				if (rx_cnt_ff == BIT_LAST) begin
					nxt_rx_cnt = 16'h0000;
					nxt_rx_sh = {serial_rx, rx_sh_ff[7:1]};
					nxt_rx_bit = rx_bit_ff + 3'h1;
					if (rx_bit_ff == 3'h7) begin
						nxt_rx_st = router_pkg::SER_STOP;
					end
				end
			end
			router_pkg::SER_STOP: begin
				if (rx_cnt_ff == BIT_LAST) begin
					nxt_rx_st = router_pkg::SER_IDLE;
					nxt_rx_vld = 1'b1;
					nxt_rx_ferr = !serial_rx;
				end
			end
			default: nxt_rx_st = router_pkg::SER_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rx_st_ff <= router_pkg::SER_IDLE;
			rx_cnt_ff <= 16'h0000;
			rx_bit_ff <= 3'h0;
			rx_sh_ff <= 8'h00;
			rx_vld_ff <= 1'b0;
			rx_ferr_ff <= 1'b0;
		end else begin
			rx_st_ff <= nxt_rx_st;
			rx_cnt_ff <= nxt_rx_cnt;
			rx_bit_ff <= nxt_rx_bit;
			rx_sh_ff <= nxt_rx_sh;
			rx_vld_ff <= nxt_rx_vld;
			rx_ferr_ff <= nxt_rx_ferr;
		end
	end

	// ************************************************************
	// Command parser
	// ************************************************************
	logic ctrl_en_ff;
	router_pkg::route_t route_ff, nxt_route;
	logic [2:0][7:0] buf_ff, nxt_buf;
	logic [1:0] len_ff, nxt_len;
	logic bad_ff, nxt_bad;
	logic done_ff, nxt_done;
	logic [7:0] good_cnt_ff, nxt_good_cnt;
	logic [7:0] bad_cnt_ff, nxt_bad_cnt;
	logic is_xp, is_mon, is_ovl;

	// Digits must be one to eight.
	assign is_xp = !bad_ff && len_ff == 2'h3 && buf_ff[0] == router_pkg::CH_T && is_dig(buf_ff[1])
		&& is_dig(buf_ff[2]);
	assign is_mon = !bad_ff && len_ff == 2'h3 && buf_ff[0] == router_pkg::CH_T
		&& buf_ff[1] == router_pkg::CH_M && is_dig(buf_ff[2]);
	assign is_ovl = !bad_ff && len_ff == 2'h2 && buf_ff[0] == router_pkg::CH_M
		&& buf_ff[1] == router_pkg::CH_C;

	always_comb begin
		nxt_route = route_ff;
		nxt_buf = buf_ff;
		nxt_len = len_ff;
		nxt_bad = bad_ff;
		nxt_done = 1'b0;
		nxt_good_cnt = good_cnt_ff;
		nxt_bad_cnt = bad_cnt_ff;
		if (rx_vld_ff && ctrl_en_ff) begin
			if (rx_ferr_ff) begin
				nxt_bad = 1'b1;
			end else if (rx_sh_ff == router_pkg::CH_CR) begin
				nxt_len = 2'h0;
				nxt_bad = 1'b0;
				if (len_ff != 2'h0 || bad_ff) begin
					nxt_done = 1'b1;
					if (is_xp || is_mon || is_ovl) begin
						nxt_good_cnt = good_cnt_ff + 8'h01;
					end else begin
						nxt_bad_cnt = bad_cnt_ff + 8'h01;
					end
					if (is_xp) begin
						nxt_route.src[dig_val(buf_ff[2])] = dig_val(buf_ff[1]);
					end
					if (is_mon) begin
						nxt_route.mon = dig_val(buf_ff[2]);
					end
					if (is_ovl) begin
						nxt_route.ovl = ovl_next(route_ff.ovl);
					end
				end
			end else if (len_ff == 2'h3) begin
				nxt_bad = 1'b1;
			end else begin
				nxt_buf[len_ff] = rx_sh_ff;
				nxt_len = len_ff + 2'h1;
			end
		end
	end

	function automatic router_pkg::ovl_t ovl_next(input router_pkg::ovl_t m);
		case (m)
			router_pkg::OVL_NONE: ovl_next = router_pkg::OVL_SRC;
			router_pkg::OVL_SRC: ovl_next = router_pkg::OVL_DST;
			router_pkg::OVL_DST: ovl_next = router_pkg::OVL_BOTH;
			router_pkg::OVL_BOTH: ovl_next = router_pkg::OVL_MATRIX;
			router_pkg::OVL_MATRIX: ovl_next = router_pkg::OVL_XY;
			default: ovl_next = router_pkg::OVL_NONE;
		endcase
	endfunction

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			route_ff <= router_pkg::ROUTE_RST;
			buf_ff <= 24'h000000;
			len_ff <= 2'h0;
			bad_ff <= 1'b0;
			done_ff <= 1'b0;
			good_cnt_ff <= 8'h00;
			bad_cnt_ff <= 8'h00;
		end else begin
			route_ff <= nxt_route;
			buf_ff <= nxt_buf;
			len_ff <= nxt_len;
			bad_ff <= nxt_bad;
			done_ff <= nxt_done;
			good_cnt_ff <= nxt_good_cnt;
			bad_cnt_ff <= nxt_bad_cnt;
		end
	end

	// Only bus one reaches the crosspoint.
	assign out_sel = route_ff.src[0];
	assign mon_sel = route_ff.mon;
	assign ovl_mode = route_ff.ovl;

	// ************************************************************
	// Status transmitter
	// ************************************************************
	logic [7:0] msg_char [router_pkg::MSG_LEN];
	router_pkg::ser_st_t tx_st_ff, nxt_tx_st;
	logic [15:0] tx_cnt_ff, nxt_tx_cnt;
	logic [2:0] tx_bit_ff, nxt_tx_bit;
	logic [7:0] tx_sh_ff, nxt_tx_sh;
	logic [3:0] tx_idx_ff, nxt_tx_idx;
	logic tx_line_ff, nxt_tx_line;
	logic [7:0] pend_ff, nxt_pend;
	logic take;

	// Bus sources in order, then the monitor bus.
	assign msg_char[0] = router_pkg::CH_S;
	assign msg_char[router_pkg::MSG_MON_IDX] = router_pkg::CH_ONE + {5'h00, route_ff.mon};
	assign msg_char[router_pkg::MSG_LAST] = router_pkg::CH_CR;
	for (genvar i = 0; i < router_pkg::NUM_BUS; i++) begin : g_dig
		assign msg_char[i+1] = router_pkg::CH_ONE + {5'h00, route_ff.src[i]};
	end

	// The message reads live state per character, so a command taken mid-message shows in later digits.
	always_comb begin
		nxt_tx_st = tx_st_ff;
		nxt_tx_cnt = tx_cnt_ff + 16'h0001;
		nxt_tx_bit = tx_bit_ff;
		nxt_tx_sh = tx_sh_ff;
		nxt_tx_idx = tx_idx_ff;
		nxt_tx_line = tx_line_ff;
		take = 1'b0;
		case (tx_st_ff)
			router_pkg::SER_IDLE: begin
				nxt_tx_cnt = 16'h0000;
				nxt_tx_line = 1'b1;
				if (pend_ff != 8'h00) begin
					take = 1'b1;
					nxt_tx_idx = 4'h0;
					nxt_tx_sh = msg_char[0];
					nxt_tx_line = 1'b0;
					nxt_tx_st = router_pkg::SER_START;
				end
			end
			router_pkg::SER_START: begin
				if (tx_cnt_ff == BIT_LAST) begin
					nxt_tx_cnt = 16'h0000;
					nxt_tx_bit = 3'h0;
					nxt_tx_line = tx_sh_ff[0];
					nxt_tx_st = router_pkg::SER_DATA;
				end
			end
			router_pkg::SER_DATA: begin
				if (tx_cnt_ff == BIT_LAST) begin
					nxt_tx_cnt = 16'h0000;
					nxt_tx_sh = {1'b0, tx_sh_ff[7:1]};
					nxt_tx_line = tx_sh_ff[1];
					nxt_tx_bit = tx_bit_ff + 3'h1;
					if (tx_bit_ff == 3'h7) begin
						nxt_tx_line = 1'b1;
						nxt_tx_st = router_pkg::SER_STOP;
					end
				end
			end
			router_pkg::SER_STOP: begin
				if (tx_cnt_ff == BIT_LAST) begin
					nxt_tx_cnt = 16'h0000;
					if (tx_idx_ff == router_pkg::MSG_LAST) begin
						nxt_tx_st = router_pkg::SER_IDLE;
					end else begin
						nxt_tx_idx = tx_idx_ff + 4'h1;
						nxt_tx_sh = msg_char[tx_idx_ff + 4'h1];
						nxt_tx_line = 1'b0;
						nxt_tx_st = router_pkg::SER_START;
					end
				end
			end
			default: nxt_tx_st = router_pkg::SER_IDLE;
		endcase
		nxt_pend = pend_ff;
		if (done_ff && !take && pend_ff != 8'hFF) begin
			nxt_pend = pend_ff + 8'h01;
		end else if (!done_ff && take) begin
			nxt_pend = pend_ff - 8'h01;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tx_st_ff <= router_pkg::SER_IDLE;
			tx_cnt_ff <= 16'h0000;
			tx_bit_ff <= 3'h0;
			tx_sh_ff <= 8'h00;
			tx_idx_ff <= 4'h0;
			tx_line_ff <= 1'b1;
			pend_ff <= 8'h00;
		end else begin
			tx_st_ff <= nxt_tx_st;
			tx_cnt_ff <= nxt_tx_cnt;
			tx_bit_ff <= nxt_tx_bit;
			tx_sh_ff <= nxt_tx_sh;
			tx_idx_ff <= nxt_tx_idx;
			tx_line_ff <= nxt_tx_line;
			pend_ff <= nxt_pend;
		end
	end

	assign serial_tx = tx_line_ff;

	// ************************************************************
	// AXI4-Lite slave
	// ************************************************************
	logic aw_hold_ff, nxt_aw_hold, w_hold_ff, nxt_w_hold;
	logic [3:0] awaddr_ff, nxt_awaddr;
	logic [31:0] wdata_ff, nxt_wdata;
	logic [3:0] wstrb_ff, nxt_wstrb;
	logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
	logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
	logic [31:0] rdata_ff, nxt_rdata;
	logic nxt_ctrl_en;

	assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
	assign s_axi_wready = !w_hold_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;

	always_comb begin
		nxt_aw_hold = aw_hold_ff;
		nxt_w_hold = w_hold_ff;
		nxt_awaddr = awaddr_ff;
		nxt_wdata = wdata_ff;
		nxt_wstrb = wstrb_ff;
		nxt_bvalid = bvalid_ff && !s_axi_bready;
		nxt_bresp = bresp_ff;
		nxt_rvalid = rvalid_ff && !s_axi_rready;
		nxt_rresp = rresp_ff;
		nxt_rdata = rdata_ff;
		nxt_ctrl_en = ctrl_en_ff;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_aw_hold = 1'b1;
			nxt_awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_w_hold = 1'b1;
			nxt_wdata = s_axi_wdata;
			nxt_wstrb = s_axi_wstrb;
		end
		if (aw_hold_ff && w_hold_ff) begin
			nxt_aw_hold = 1'b0;
			nxt_w_hold = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = router_pkg::RESP_OKAY;
			if (awaddr_ff == router_pkg::OFS_CTRL) begin
				if (wstrb_ff[0]) begin
					nxt_ctrl_en = wdata_ff[router_pkg::CTRL_EN_BIT];
				end
			end else if (awaddr_ff != router_pkg::OFS_ROUTE && awaddr_ff != router_pkg::OFS_MON
				&& awaddr_ff != router_pkg::OFS_STAT) begin
				nxt_bresp = router_pkg::RESP_SLVERR;
			end
		end
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_rvalid = 1'b1;
			nxt_rresp = router_pkg::RESP_OKAY;
			if (s_axi_araddr == router_pkg::OFS_CTRL) begin
				nxt_rdata = 32'(ctrl_en_ff) << router_pkg::CTRL_EN_BIT;
			end else if (s_axi_araddr == router_pkg::OFS_ROUTE) begin
				nxt_rdata = {8'h00, route_ff.src};
			end else if (s_axi_araddr == router_pkg::OFS_MON) begin
				nxt_rdata = (32'(route_ff.ovl) << router_pkg::MON_OVL_LSB) | 32'(route_ff.mon);
			end else if (s_axi_araddr == router_pkg::OFS_STAT) begin
				nxt_rdata = (32'(pend_ff) << router_pkg::STAT_PEND_LSB)
					| (32'(bad_cnt_ff) << router_pkg::STAT_BAD_LSB) | 32'(good_cnt_ff);
			end else begin
				nxt_rdata = 32'h00000000;
				nxt_rresp = router_pkg::RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			awaddr_ff <= 4'h0;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= 2'h0;
			rvalid_ff <= 1'b0;
			rresp_ff <= 2'h0;
			rdata_ff <= 32'h00000000;
			ctrl_en_ff <= router_pkg::CTRL_EN_RST;
		end else begin
			aw_hold_ff <= nxt_aw_hold;
			w_hold_ff <= nxt_w_hold;
			awaddr_ff <= nxt_awaddr;
			wdata_ff <= nxt_wdata;
			wstrb_ff <= nxt_wstrb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rresp_ff <= nxt_rresp;
			rdata_ff <= nxt_rdata;
			ctrl_en_ff <= nxt_ctrl_en;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;
endmodule

// ===== router_pkg.sv
package router_pkg;
	// ************************************************************
	// Serial timing
	// ************************************************************
	localparam int CLK_HZ = 250_000_000;
	localparam int BAUD_RATE = 38_400;
	localparam int BIT_CYC = CLK_HZ / BAUD_RATE;
	localparam int CNT_W = 16;
	// ************************************************************
	// Characters and message layout
	// ************************************************************
	localparam logic [7:0] CH_T = 8'h54;
	localparam logic [7:0] CH_M = 8'h4D;
	localparam logic [7:0] CH_C = 8'h43;
	localparam logic [7:0] CH_S = 8'h53;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_ONE = 8'h31;
	localparam logic [7:0] CH_EIGHT = 8'h38;
	localparam int NUM_BUS = 8;
	localparam int MSG_LEN = 11;
	localparam logic [3:0] MSG_LAST = 4'hA;
	localparam logic [3:0] MSG_MON_IDX = 4'h9;
	// ************************************************************
	// Register map
	// ************************************************************
	localparam int AXI_AW = 4;
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_ROUTE = 4'h4;
	localparam logic [3:0] OFS_MON = 4'h8;
	localparam logic [3:0] OFS_STAT = 4'hC;
	localparam int CTRL_EN_BIT = 0;
	localparam logic CTRL_EN_RST = 1'b1;
	localparam int MON_OVL_LSB = 4;
	localparam int STAT_BAD_LSB = 8;
	localparam int STAT_PEND_LSB = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [5:0] {
		OVL_NONE = 6'h01,
		OVL_SRC = 6'h02,
		OVL_DST = 6'h04,
		OVL_BOTH = 6'h08,
		OVL_MATRIX = 6'h10,
		OVL_XY = 6'h20
	} ovl_t;
	typedef enum logic [3:0] {
		SER_IDLE = 4'h1,
		SER_START = 4'h2,
		SER_DATA = 4'h4,
		SER_STOP = 4'h8
	} ser_st_t;
	typedef struct packed {
		ovl_t ovl;
		logic [2:0] mon;
		logic [NUM_BUS-1:0][2:0] src;
	} route_t;
	localparam route_t ROUTE_RST = '{ovl: OVL_NONE, mon: 3'h0, src: 24'h000000};
endpackage

// ===== router_monitor.sv
`timescale 1ns/10ps
module router_monitor #(
	parameter int BIT_CYCLES = 16 // Clocks per serial bit.
) (
	input wire logic mclk, // Clock.
	input wire logic rst_b, // Reset.
	input wire logic serial_tx, // Status line.
	input wire logic [2:0] out_sel, // Routed source.
	input wire logic [2:0] mon_sel, // Monitor bus.
	input wire router_pkg::ovl_t ovl_mode, // Overlay mode.
	input wire logic s_axi_awvalid, // AW valid.
	input wire logic s_axi_awready, // AW ready.
	input wire logic s_axi_wvalid, // W valid.
	input wire logic s_axi_wready, // W ready.
	input wire logic [1:0] s_axi_bresp, // B code.
	input wire logic s_axi_bvalid, // B valid.
	input wire logic s_axi_bready, // B ready.
	input wire logic [router_pkg::AXI_AW-1:0] s_axi_araddr, // AR address.
	input wire logic s_axi_arvalid, // AR valid.
	input wire logic s_axi_arready, // AR ready.
	input wire logic [31:0] s_axi_rdata, // R data.
	input wire logic [1:0] s_axi_rresp, // R code.
	input wire logic s_axi_rvalid, // R valid.
	input wire logic s_axi_rready // R ready.
);
	logic [15:0] low_cnt_ff;
	logic [15:0] nxt_low_cnt;
	logic ar_take;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	assign ar_take = s_axi_arvalid && s_axi_arready;
	// A low run on the line is a start bit plus zero bits, so it must span whole bits.
	always_comb begin
		nxt_low_cnt = serial_tx ? 16'h0000 : low_cnt_ff + 16'h0001;
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			low_cnt_ff <= 16'h0000;
		end else begin
			low_cnt_ff <= nxt_low_cnt;
		end
	end
	a_tx_bit_len: assert property (
		$rose(serial_tx) |-> low_cnt_ff != 16'h0000 && (low_cnt_ff % BIT_CYCLES) == 0)
		else $error("serial low run not whole bits");
	a_ovl_onehot: assert property ($onehot(ovl_mode)) else $error("overlay not one-hot");
	a_ovl_step: assert property (
		!$stable(ovl_mode) |-> $past(ovl_mode) == {ovl_mode[0], ovl_mode[5:1]})
		else $error("overlay skipped a step");
	a_route_bus1: assert property (
		ar_take && s_axi_araddr == router_pkg::OFS_ROUTE |=> s_axi_rdata[2:0] == $past(out_sel))
		else $error("output select differs from bus one");
	a_mon_state: assert property (
		ar_take && s_axi_araddr == router_pkg::OFS_MON |=>
		s_axi_rdata[2:0] == $past(mon_sel) && s_axi_rdata[9:4] == $past(ovl_mode))
		else $error("monitor readback differs");
	a_unmapped_err: assert property (
		ar_take && s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == router_pkg::RESP_SLVERR)
		else $error("unmapped read not refused");
	a_read_answer: assert property (ar_take |=> s_axi_rvalid) else $error("read not answered");
	a_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
	a_resp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	c_wrap: cover property ($past(ovl_mode) == router_pkg::OVL_XY && ovl_mode == router_pkg::OVL_NONE);
	c_tx_start: cover property ($fell(serial_tx));
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == router_pkg::RESP_SLVERR);
endmodule
bind ascii_router_command_parser router_monitor #(.BIT_CYCLES(BIT_CYCLES)) i_mon (
	.mclk(mclk), .rst_b(rst_b), .serial_tx(serial_tx), .out_sel(out_sel), .mon_sel(mon_sel),
	.ovl_mode(ovl_mode), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// ===== serial_host_model.sv
`timescale 1ns/10ps
module serial_host_model #(
	parameter int BIT_CYCLES = 16 // Clocks per serial bit.
) (
	input wire logic mclk, // Clock.
	input wire logic serial_tx, // Status line from the device.
	output logic serial_rx // Command line to the device.
);
	logic [7:0] rx_q[$];
	logic [7:0] rx_byte;
	// one sender only, idle line high
	initial serial_rx = 1'b1;
	// start, eight data bits first bit lowest, stop
	task automatic send_byte(input logic [7:0] b, input logic stp = 1'b1);
		logic [9:0] frm;
		frm = {stp, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			serial_rx <= frm[i];
			repeat (BIT_CYCLES) @(posedge mclk);
		end
		// A broken stop bit is followed by one idle bit, so the next start edge is clean.
		if (!stp) begin
			serial_rx <= 1'b1;
			repeat (BIT_CYCLES) @(posedge mclk);
		end
	endtask
	task automatic send_line(input string s);
		@(posedge mclk);
		foreach (s[i]) send_byte(s[i]);
		send_byte(8'h0D);
	endtask
	always begin
		@(negedge serial_tx);
		repeat (BIT_CYCLES / 2) @(posedge mclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYCLES) @(posedge mclk);
			rx_byte[i] = serial_tx;
		end
		repeat (BIT_CYCLES) @(posedge mclk);
		rx_q.push_back(rx_byte);
	end
endmodule

// ===== test_ascii_router_command_parser.sv
`timescale 1ns/10ps
module test_ascii_router_command_parser;
	localparam int BITC = 16;
	logic mclk = 1'b0, rst_b = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
	logic serial_rx, serial_tx, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [2:0] out_sel, mon_sel, mon_e;
	router_pkg::ovl_t ovl_mode;
	logic [2:0] src_e[8] = '{default: 3'h0};
	logic [5:0] ovl_e = 6'h01;
	logic [7:0] good_e = 8'h00, bad_e = 8'h00;
	int error_cnt = 0, checked = 0;
	ascii_router_command_parser #(.BIT_CYCLES(BITC)) i_dut (.mclk(mclk), .rst_b(rst_b),
		.serial_rx(serial_rx), .serial_tx(serial_tx), .out_sel(out_sel), .mon_sel(mon_sel), .ovl_mode(ovl_mode),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	serial_host_model #(.BIT_CYCLES(BITC)) i_host (.mclk(mclk), .serial_tx(serial_tx), .serial_rx(serial_rx));
	initial forever #2 mclk = ~mclk;
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tmo();
		error_cnt++;
		$display("mismatch at %0t: wait timed out", $time);
		stop_test();
	endtask
	// A nonzero lag holds the response ready low for that many cycles so the slave must keep its answer.
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] st, input logic [1:0] er,
		input int lag = 0);
		int n;
		n = 0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= (lag == 0);
		do begin
			@(posedge mclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (n >= lag) s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid && s_axi_bready) && n < 100);
		if (!(s_axi_bvalid && s_axi_bready)) tmo();
		chk(s_axi_bresp, er);
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er, input int lag = 0);
		int n;
		n = 0;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (lag == 0);
		do begin
			@(posedge mclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (n >= lag) s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid && s_axi_rready) && n < 100);
		if (!(s_axi_rvalid && s_axi_rready)) tmo();
		chk(s_axi_rdata, ed);
		chk(s_axi_rresp, er);
		s_axi_rready <= 1'b0;
	endtask
	task automatic reg_chk();
		logic [31:0] rt;
		rt = 32'h00000000;
		for (int i = 0; i < 8; i++) rt[3*i +: 3] = src_e[i];
		axi_rd(router_pkg::OFS_CTRL, 32'h00000001, router_pkg::RESP_OKAY);
		axi_rd(router_pkg::OFS_ROUTE, rt, router_pkg::RESP_OKAY);
		axi_rd(router_pkg::OFS_MON, {22'h000000, ovl_e, 1'b0, mon_e}, router_pkg::RESP_OKAY);
		axi_rd(router_pkg::OFS_STAT, {16'h0000, bad_e, good_e}, router_pkg::RESP_OKAY);
	endtask
	// Waits for one whole status message and compares it with the expected selections.
	task automatic msg_chk();
		int n;
		n = 0;
		while (i_host.rx_q.size() < 11) begin
			@(posedge mclk);
			n++;
			if (n > 5000) tmo();
		end
		chk(i_host.rx_q.pop_front(), router_pkg::CH_S);
		for (int b = 0; b < 8; b++) chk(i_host.rx_q.pop_front(), 8'h31 + src_e[b]);
		chk(i_host.rx_q.pop_front(), 8'h31 + mon_e);
		chk(i_host.rx_q.pop_front(), router_pkg::CH_CR);
		chk(out_sel, src_e[0]);
		chk(mon_sel, mon_e);
		chk(ovl_mode, ovl_e);
	endtask
	task automatic cmd(input string s);
		i_host.send_line(s);
		msg_chk();
	endtask
	task automatic t_reset();
		chk(serial_tx, 1'b1);
		reg_chk();
		$display("test reset done");
	endtask
	task automatic t_route();
		for (int d = 1; d <= 8; d++) begin
			src_e[d-1] = 3'(8 - d);
			good_e++;
			cmd($sformatf("T%0d%0d", 9 - d, d));
		end
		$display("test route done");
	endtask
	task automatic t_monitor();
		for (int i = 0; i < 2; i++) begin
			mon_e = (i == 0) ? 3'h7 : 3'h2;
			good_e++;
			cmd((i == 0) ? "TM8" : "TM3");
		end
		$display("test monitor done");
	endtask
	task automatic t_overlay();
		for (int i = 0; i < 7; i++) begin
			ovl_e = {ovl_e[4:0], ovl_e[5]};
			good_e++;
			cmd("MC");
		end
		reg_chk();
		$display("test overlay done");
	endtask
	task automatic t_bad();
		string bl[5] = '{"T09", "TM9", "T1234", "MX", "T8"};
		foreach (bl[i]) begin
			bad_e++;
			cmd(bl[i]);
		end
		// A character with a broken stop bit spoils its whole line.
		bad_e++;
		i_host.send_byte(router_pkg::CH_T, 1'b0);
		cmd("");
		reg_chk();
		$display("test refused done");
	endtask
	// Two commands in a row: the second reply must queue behind the first.
	task automatic t_back2back();
		src_e[0] = 3'h1;
		good_e = good_e + 8'h02;
		i_host.send_line("T21");
		i_host.send_line("T32");
		msg_chk();
		src_e[1] = 3'h2;
		msg_chk();
		$display("test back to back done");
	endtask
	task automatic t_regs();
		axi_wr(router_pkg::OFS_CTRL, 32'h00000000, 4'hE, router_pkg::RESP_OKAY);
		axi_wr(router_pkg::OFS_CTRL, 32'h00000000, 4'hF, router_pkg::RESP_OKAY);
		i_host.send_line("T55");
		repeat (400) @(posedge mclk);
		chk(i_host.rx_q.size(), 0);
		axi_wr(router_pkg::OFS_CTRL, 32'h00000001, 4'hF, router_pkg::RESP_OKAY, 5);
		// A bare carriage return is no command: no reply and no count.
		i_host.send_line("");
		axi_wr(4'h2, 32'h00000000, 4'hF, router_pkg::RESP_SLVERR);
		axi_rd(4'h6, 32'h00000000, router_pkg::RESP_SLVERR, 3);
		axi_wr(router_pkg::OFS_ROUTE, 32'hFFFFFFFF, 4'hF, router_pkg::RESP_OKAY);
		reg_chk();
		$display("test registers done");
	endtask
	initial begin
		mon_e = 3'h0;
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		t_reset();
		t_route();
		t_monitor();
		t_overlay();
		t_bad();
		t_back2back();
		t_regs();
		stop_test();
	end
endmodule
